// ---- tb_top.sv ----
// register, address counting and channel end tests for the dma counters
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [6:0] ch_active = 7'h0;
    logic [6:0] desc_load = 7'h0;
    logic [31:0] desc_addr = 32'h0;
    logic [2:0] acc_ch = 3'h0;
    logic [6:0] dev_end = 7'h0;
    logic [6:0] xfer_end = 7'h0;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic hready, hresp, addr_end;
    logic [31:0] hrdata, acc_addr, r;
    logic [2:0] acc_bytes, acc_hsize;
    logic [6:0] ch_end;
    logic [2:0] widths[$];
    logic [31:0] addrs[$];
    logic [2:0] sizes[$];
    logic [6:0] pkt_ev = 7'h0;
    logic [15:0] pkt_left = 16'h0100;
    logic [31:0] exp_a[5] = '{32'h1001, 32'h1002, 32'h1004, 32'h1008,
        32'h100a};
    logic [2:0] exp_s[5] = '{uda_pkg::HSIZE_BYTE, uda_pkg::HSIZE_HALF,
        uda_pkg::HSIZE_WORD, uda_pkg::HSIZE_HALF, uda_pkg::HSIZE_BYTE};
    int errors = 0;
    int checks = 0;
    int cyc = 0;

    always #2 clk = ~clk;

    uda_dma_addr i_dut (.CLOCK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(uda_pkg::HSIZE_WORD),
        .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
        .HRESP(hresp), .HRDATA(hrdata), .CH_ACTIVE(ch_active),
        .DESC_LOAD(desc_load), .DESC_ADDR(desc_addr), .ACC_CH(acc_ch),
        .ADDR_END(addr_end), .PKT_LEFT(pkt_left), .USB_PKT_END(pkt_ev),
        .USB_DEV_END(dev_end), .USB_XFER_END(xfer_end),
        .ACC_ADDR(acc_addr), .ACC_BYTES(acc_bytes), .ACC_HSIZE(acc_hsize),
        .CH_END(ch_end));

    uda_bus_side i_side (.clk(clk), .rst(rst), .go(go), .slow(slow),
        .acc_bytes(acc_bytes), .addr_end(addr_end));

    always @(posedge clk)
    begin
        if (addr_end === 1'b1)
        begin
            widths.push_back(acc_bytes);
            addrs.push_back(acc_addr);
            sizes.push_back(acc_hsize);
        end
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            $display("unexpected at %0t: run did not finish", $time);
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got,
                     exp);
        end
    endtask

    // one single transfer; read data is taken at the data phase's last edge
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0, "okay response");
    endtask

    // from idle the bus side takes go at one edge only: exactly one access
    task automatic pulse_go();
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    function automatic logic [11:0] adr(input logic [11:0] b, input int ch);
        return b + 12'(ch) * uda_pkg::CH_STRIDE;
    endfunction

    task automatic usb_ev(input logic [6:0] dv, input logic [6:0] xf);
        @(posedge clk);
        dev_end <= dv;
        xfer_end <= xf;
        @(posedge clk);
        dev_end <= 7'h0;
        xfer_end <= 7'h0;
        repeat (2) @(posedge clk);
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, uda_pkg::PTR_BASE, 32'h0, r);
        chk(r, uda_pkg::PTR_RESET, "pointer reset");
        bus(1'b0, 12'h3fc, 32'h0, r);
        chk(r, 32'h0, "unmapped read");
        bus(1'b0, uda_pkg::BEND_BASE, 32'h0, r);
        chk(r, uda_pkg::BEND_RESET, "buffer end reset");
        // odd values on channels 0, 2, 4 and 6 show that no alignment is imposed on a pointer
        for (int c = 0; c < 7; c++)
            bus(1'b1, adr(uda_pkg::PTR_BASE, c), 32'h13579bd1 + c, r);
        for (int c = 0; c < 7; c++)
        begin
            bus(1'b0, adr(uda_pkg::PTR_BASE, c), 32'h0, r);
            chk(r, 32'h13579bd1 + c, "pointer readback");
        end
        ch_active <= 7'h04;
        bus(1'b1, adr(uda_pkg::PTR_BASE, 2), 32'h55550000, r);
        bus(1'b0, adr(uda_pkg::PTR_BASE, 2), 32'h0, r);
        chk(r, 32'h13579bd3, "write while active");
        bus(1'b0, adr(uda_pkg::STAT_BASE, 2), 32'h0, r);
        chk({31'h0, r[uda_pkg::STAT_IGN_BIT]}, 32'h1, "ignored flag");
        chk({31'h0, r[uda_pkg::STAT_ACTIVE_BIT]}, 32'h1, "active bit");
        ch_active <= 7'h00;
        // unaligned start and end inside one word-spanning buffer
        bus(1'b1, adr(uda_pkg::PTR_BASE, 1), 32'h00001001, r);
        bus(1'b1, adr(uda_pkg::BEND_BASE, 1), 32'h0000100a, r);
        acc_ch <= 3'h1;
        ch_active <= 7'h02;
        repeat (3) @(posedge clk);
        go <= 1'b1;
        repeat (60) @(posedge clk);
        go <= 1'b0;
        chk(widths.size(), 5, "access count");
        if (widths.size() == 5)
        begin
            chk(widths[0], 3'h1, "first width");
            chk(widths[1], 3'h2, "second width");
            chk(widths[2], 3'h4, "word width");
            chk(widths[3], 3'h2, "tail width");
            chk(widths[4], 3'h1, "last width");
            for (int i = 0; i < 5; i++)
            begin
                chk(addrs[i], exp_a[i], "access address");
                chk(sizes[i], exp_s[i], "access size");
            end
        end
        chk(ch_end[1], 1'b1, "buffer end reached");
        bus(1'b0, adr(uda_pkg::PTR_BASE, 1), 32'h0, r);
        chk(r, 32'h0000100b, "pointer advanced");
        bus(1'b0, uda_pkg::PKT_BASE + uda_pkg::PKT_STRIDE, 32'h0, r);
        chk(r, 32'h00001001, "packet start");
        bus(1'b0, uda_pkg::PKT_BASE + uda_pkg::PKT_STRIDE + 12'h4, 32'h0, r);
        chk(r, 32'h0000100a, "packet end");
        bus(1'b1, adr(uda_pkg::STAT_BASE, 1), 32'h2, r);
        @(posedge clk);
        chk(ch_end[1], 1'b0, "channel end cleared");
        ch_active <= 7'h00;
        @(posedge clk);
        desc_addr <= 32'h20000003;
        desc_load <= 7'h08;
        @(posedge clk);
        desc_load <= 7'h00;
        bus(1'b0, adr(uda_pkg::PTR_BASE, 3), 32'h0, r);
        chk(r, 32'h20000003, "descriptor load");
        ch_active <= 7'h18;
        usb_ev(7'h00, 7'h08);
        chk(ch_end[3], 1'b0, "transfer end without stop bit");
        bus(1'b1, adr(uda_pkg::CTRL_BASE, 3), 32'h1, r);
        usb_ev(7'h00, 7'h08);
        chk(ch_end[3], 1'b1, "transfer end with stop bit");
        usb_ev(7'h10, 7'h00);
        chk(ch_end[4], 1'b1, "usb device end");
        // two packets on channel 5, the second one cut short by the usb side
        bus(1'b1, adr(uda_pkg::PTR_BASE, 5), 32'h00002002, r);
        acc_ch <= 3'h5;
        ch_active <= 7'h20;
        repeat (3) @(posedge clk);
        pulse_go();
        pkt_ev <= 7'h20;
        @(posedge clk);
        pkt_ev <= 7'h00;
        pkt_left <= 16'h0003;
        repeat (3) @(posedge clk);
        pulse_go();
        chk(widths.size(), 7, "packet access count");
        if (widths.size() == 7)
        begin
            chk(widths[5], 3'h2, "halfword at packet start");
            chk(widths[6], 3'h2, "narrowed at packet end");
            chk(addrs[6], 32'h00002004, "next packet address");
        end
        bus(1'b0, uda_pkg::PKT_BASE + 12'h028, 32'h0, r);
        chk(r, 32'h00002004, "second packet start");
        bus(1'b0, uda_pkg::PKT_BASE + 12'h02c, 32'h0, r);
        chk(r, 32'h00002005, "second packet end");
        finish_test();
    end
endmodule

// ---- uda_ahb.sv ----
// ahb-lite slave front end: zero-wait writes, one wait state on reads
`timescale 1ns/1ns
module uda_ahb
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready_in,
    output logic hready_out,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic wr_en,
    output logic [11:0] reg_addr,
    output logic [31:0] wr_data,
    input wire logic [31:0] rd_data
);
    typedef struct packed {
        logic [11:0] addr;
        logic wr_pend;
        logic rd_pend;
        logic ready;
        logic resp;
        logic [31:0] rdata;
    } uda_ahb_s;

    uda_ahb_s s_q;
    uda_ahb_s s_d;
    logic accept;

    assign accept = hsel && htrans[1] && hready_in;

    always_comb
    begin
        s_d = s_q;
        s_d.wr_pend = 1'b0;
        s_d.resp = 1'b0;
        // read data is taken one cycle late so a write just ended is seen
        if (s_q.rd_pend)
        begin
            s_d.rdata = rd_data;
            s_d.rd_pend = 1'b0;
            s_d.ready = 1'b1;
        end
        if (accept)
        begin
            s_d.addr = haddr[11:0];
            s_d.wr_pend = hwrite;
            s_d.rd_pend = !hwrite;
            s_d.ready = hwrite;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '{addr: 12'h0, wr_pend: 1'b0, rd_pend: 1'b0, ready: 1'b1,
                     resp: 1'b0, rdata: 32'h0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign hready_out = s_q.ready;
    assign hresp = s_q.resp;
    assign hrdata = s_q.rdata;
    assign wr_en = s_q.wr_pend;
    assign reg_addr = s_q.addr;
    assign wr_data = hwdata;
endmodule

// ---- uda_bus_side.sv ----
// behavioural bus side of the dma unit: issues address phases on demand
`timescale 1ns/1ns
module uda_bus_side
(
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic slow,
    input wire logic [2:0] acc_bytes,
    output logic addr_end
);
    logic [2:0] gap_q;

    // the gap lets the counter's answer settle before the next request
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gap_q <= 3'h0;
            addr_end <= 1'b0;
        end
        else if (addr_end)
        begin
            addr_end <= 1'b0;
            gap_q <= slow ? 3'h4 : 3'h2;
        end
        else if (gap_q != 3'h0)
            gap_q <= gap_q - 3'h1;
        else
            addr_end <= go && (acc_bytes != 3'h0);
    end
endmodule

// ---- uda_chan.sv ----
// one dma channel: buffer pointer, buffer end and packet bookkeeping
`timescale 1ns/1ns
module uda_chan
#(
    parameter int PKT_W = 16
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic active,
    input wire logic ctrl_we,
    input wire logic ptr_we,
    input wire logic bend_we,
    input wire logic stat_we,
    input wire logic [31:0] wdata,
    input wire logic desc_load,
    input wire logic [31:0] desc_addr,
    input wire logic acc_end,
    input wire logic [PKT_W-1:0] pkt_left,
    input wire logic usb_pkt_end,
    input wire logic usb_dev_end,
    input wire logic usb_xfer_end,
    output logic [31:0] ptr,
    output logic [31:0] bend,
    output logic stop_en,
    output logic end_flag,
    output logic ign_flag,
    output logic [31:0] pkt_start,
    output logic [31:0] pkt_end,
    output logic [2:0] nxt_bytes
);
    typedef struct packed {
        logic [31:0] ptr;
        logic [31:0] bend;
        logic stop;
        logic endf;
        logic ign;
        logic first;
        logic [31:0] pstart;
        logic [31:0] pend;
    } uda_chan_s;

    uda_chan_s s_q;
    uda_chan_s s_d;
    logic [32:0] room;
    logic [2:0] rlim;
    logic [2:0] plim;
    logic [2:0] lim;
    logic [2:0] bytes;
    logic adv;

    always_comb
    begin
        // bytes left up to and including the buffer end address
        if (s_q.ptr > s_q.bend)
        begin
            room = 33'h0;
        end
        else
        begin
            room = {1'b0, s_q.bend} - {1'b0, s_q.ptr} + 33'h1;
        end
        rlim = (room > 33'h4) ? uda_pkg::WORD_BYTES : room[2:0];
        plim = (pkt_left > PKT_W'(4)) ? uda_pkg::WORD_BYTES : pkt_left[2:0];
        lim = (rlim < plim) ? rlim : plim;
        // access never crosses a word boundary and stays a legal ahb size
        if (s_q.endf || lim == 3'h0)
        begin
            bytes = 3'h0;
        end
        else if (s_q.ptr[0])
        begin
            bytes = 3'h1;
        end
        else if (s_q.ptr[1])
        begin
            bytes = (lim >= 3'h2) ? 3'h2 : 3'h1;
        end
        else if (lim == uda_pkg::WORD_BYTES)
        begin
            bytes = uda_pkg::WORD_BYTES;
        end
        else
        begin
            bytes = (lim >= 3'h2) ? 3'h2 : 3'h1;
        end
    end

    assign adv = acc_end && active && bytes != 3'h0;

    always_comb
    begin
        s_d = s_q;
        if (ctrl_we)
        begin
            s_d.stop = wdata[uda_pkg::CTRL_STOP_BIT];
        end
        if (bend_we)
        begin
            s_d.bend = wdata;
        end
        if (stat_we && wdata[uda_pkg::STAT_END_BIT])
        begin
            s_d.endf = 1'b0;
        end
        if (stat_we && wdata[uda_pkg::STAT_IGN_BIT])
        begin
            s_d.ign = 1'b0;
        end
        if (desc_load)
        begin
            s_d.ptr = desc_addr;
            s_d.first = 1'b1;
            s_d.endf = 1'b0;
        end
        else if (ptr_we && active)
        begin
            // pointer untouched, the attempt is only recorded
            s_d.ign = 1'b1;
        end
        else if (ptr_we)
        begin
            s_d.ptr = wdata;
            s_d.first = 1'b1;
            s_d.endf = 1'b0;
        end
        else if (adv)
        begin
            s_d.ptr = s_q.ptr + 32'(bytes);
            s_d.pend = s_q.ptr + 32'(bytes) - 32'h1;
            if (s_q.first)
            begin
                s_d.pstart = s_q.ptr;
                s_d.first = 1'b0;
            end
            if (room == 33'(bytes))
            begin
                s_d.endf = 1'b1;
            end
        end
        if (usb_pkt_end)
        begin
            s_d.first = 1'b1;
        end
        // end events win over a software clear in the same cycle
        if (usb_dev_end || (usb_xfer_end && s_q.stop))
        begin
            s_d.endf = 1'b1;
            s_d.first = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '{ptr: uda_pkg::PTR_RESET, bend: uda_pkg::BEND_RESET,
                     stop: uda_pkg::CTRL_RESET, endf: 1'b0, ign: 1'b0,
                     first: 1'b1, pstart: uda_pkg::PTR_RESET,
                     pend: uda_pkg::PTR_RESET};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign ptr = s_q.ptr;
    assign bend = s_q.bend;
    assign stop_en = s_q.stop;
    assign end_flag = s_q.endf;
    assign ign_flag = s_q.ign;
    assign pkt_start = s_q.pstart;
    assign pkt_end = s_q.pend;
    assign nxt_bytes = bytes;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence blocked_write;
        ptr_we && active && !desc_load;
    endsequence

    a_ptr_write_ignored: assert property (
        blocked_write |=> $stable(s_q.ptr) && s_q.ign)
        else $error("pointer changed on write while channel active");
    a_ptr_sw_load: assert property (
        ptr_we && !active && !desc_load |=> s_q.ptr == $past(wdata))
        else $error("idle pointer write not taken at byte address");
    a_ptr_desc_load: assert property (
        desc_load |=> s_q.ptr == $past(desc_addr) && s_q.first)
        else $error("descriptor load did not set the pointer");
    a_ptr_advance_width: assert property (
        adv && !desc_load && !ptr_we
        |=> s_q.ptr == $past(s_q.ptr) + 32'($past(bytes)))
        else $error("pointer not advanced by access width");
    a_access_word_bound: assert property (
        bytes != 3'h0 |-> ({1'b0, s_q.ptr[1:0]} + bytes) <= 3'h4
        && 33'(bytes) <= room)
        else $error("access crosses word boundary or buffer end");
    a_pkt_start_addr: assert property (
        adv && s_q.first && !desc_load && !ptr_we
        && !usb_pkt_end && !usb_dev_end && !(usb_xfer_end && s_q.stop)
        |=> s_q.pstart == $past(s_q.ptr) && !s_q.first)
        else $error("packet start address not captured");
    a_pkt_end_addr: assert property (
        adv && !desc_load && !ptr_we
        |=> s_q.pend == $past(s_q.ptr) + 32'($past(bytes)) - 32'h1)
        else $error("packet end address not last accessed byte");
    a_end_by_xfer_stop: assert property (
        usb_xfer_end && s_q.stop |=> s_q.endf ##1 (s_q.endf || $past(stat_we)
        || $past(desc_load) || $past(ptr_we)))
        else $error("end of transfer did not end the channel");
endmodule

// ---- uda_dma_addr.sv ----
// usb device dma address counters for all channels behind an ahb-lite slave
//
// What this block does
// - each channel holds a 32-bit pointer: where its bus transfer begins
// - start and end addresses may sit on any byte
// - pointer grows by the access width when an address phase ends
// - accesses are a word, narrower at unaligned packet start or end
// - packet start is channel start, else the next address to access
// - packet end is channel end, else the last address accessed
// - channel start comes from a software write or a descriptor load
// - channel ends at buffer end, usb side, or usb transfer end if enabled
// - pointer registers sit at 0x304 plus 0x10 per channel
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ns
module uda_dma_addr
#(
    parameter int NCH = uda_pkg::NCH,
    parameter int PKT_W = uda_pkg::PKT_W
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    input wire logic [NCH-1:0] CH_ACTIVE,
    input wire logic [NCH-1:0] DESC_LOAD,
    input wire logic [31:0] DESC_ADDR,
    input wire logic [2:0] ACC_CH,
    input wire logic ADDR_END,
    input wire logic [PKT_W-1:0] PKT_LEFT,
    input wire logic [NCH-1:0] USB_PKT_END,
    input wire logic [NCH-1:0] USB_DEV_END,
    input wire logic [NCH-1:0] USB_XFER_END,
    output logic [31:0] ACC_ADDR,
    output logic [2:0] ACC_BYTES,
    output logic [2:0] ACC_HSIZE,
    output logic [NCH-1:0] CH_END
);
    typedef struct packed {
        logic [31:0] addr;
        logic [2:0] bytes;
        logic [2:0] hsize;
    } uda_top_s;

    uda_top_s s_q;
    uda_top_s s_d;
    logic wr_en;
    logic [11:0] reg_addr;
    logic [31:0] wr_data;
    logic [31:0] rd_data;
    logic [11:0] rel;
    logic [11:0] prel;
    logic [2:0] rch;
    logic [2:0] pch;
    logic main_hit;
    logic pkt_hit;
    logic [31:0] ptr_w [NCH];
    logic [31:0] bend_w [NCH];
    logic [31:0] pstart_w [NCH];
    logic [31:0] pend_w [NCH];
    logic [2:0] bytes_w [NCH];
    logic [NCH-1:0] stop_w;
    logic [NCH-1:0] end_w;
    logic [NCH-1:0] ign_w;

    uda_ahb u_ahb
    (
        .clk(CLOCK),
        .rst(RST),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hwdata(HWDATA),
        .hready_in(HREADY),
        .hready_out(HREADYOUT),
        .hresp(HRESP),
        .hrdata(HRDATA),
        .wr_en(wr_en),
        .reg_addr(reg_addr),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    // one decode serves both paths: a write strobe and a read share reg_addr
    always_comb
    begin
        rel = reg_addr - uda_pkg::CTRL_BASE;
        prel = reg_addr - uda_pkg::PKT_BASE;
        rch = rel[6:4];
        pch = prel[5:3];
        main_hit = reg_addr >= uda_pkg::CTRL_BASE && rel[11:7] == 5'h0
            && 32'(rch) < NCH;
        pkt_hit = reg_addr >= uda_pkg::PKT_BASE && prel[11:6] == 6'h0
            && 32'(pch) < NCH;
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : g_ch
            logic sel;
            assign sel = wr_en && main_hit && 32'(rch) == g;
            uda_chan #(.PKT_W(PKT_W)) u_ch
            (
                .clk(CLOCK),
                .rst(RST),
                .active(CH_ACTIVE[g]),
                .ctrl_we(sel && rel[3:2] == uda_pkg::FLD_CTRL),
                .ptr_we(sel && rel[3:2] == uda_pkg::FLD_PTR),
                .bend_we(sel && rel[3:2] == uda_pkg::FLD_BEND),
                .stat_we(sel && rel[3:2] == uda_pkg::FLD_STAT),
                .wdata(wr_data),
                .desc_load(DESC_LOAD[g]),
                .desc_addr(DESC_ADDR),
                .acc_end(ADDR_END && 32'(ACC_CH) == g),
                .pkt_left(PKT_LEFT),
                .usb_pkt_end(USB_PKT_END[g]),
                .usb_dev_end(USB_DEV_END[g]),
                .usb_xfer_end(USB_XFER_END[g]),
                .ptr(ptr_w[g]),
                .bend(bend_w[g]),
                .stop_en(stop_w[g]),
                .end_flag(end_w[g]),
                .ign_flag(ign_w[g]),
                .pkt_start(pstart_w[g]),
                .pkt_end(pend_w[g]),
                .nxt_bytes(bytes_w[g])
            );
        end
    endgenerate

    // read mux; reserved bits and unmapped addresses read as zero
    always_comb
    begin
        rd_data = 32'h0;
        if (main_hit)
        begin
            case (rel[3:2])
                uda_pkg::FLD_CTRL:
                begin
                    rd_data[uda_pkg::CTRL_STOP_BIT] = stop_w[rch];
                end
                uda_pkg::FLD_PTR:
                begin
                    rd_data = ptr_w[rch];
                end
                uda_pkg::FLD_BEND:
                begin
                    rd_data = bend_w[rch];
                end
                uda_pkg::FLD_STAT:
                begin
                    rd_data[uda_pkg::STAT_ACTIVE_BIT] = CH_ACTIVE[rch];
                    rd_data[uda_pkg::STAT_END_BIT] = end_w[rch];
                    rd_data[uda_pkg::STAT_IGN_BIT] = ign_w[rch];
                end
                default:
                begin
                    rd_data = 32'h0;
                end
            endcase
        end
        else if (pkt_hit)
        begin
            rd_data = prel[2] ? pend_w[pch] : pstart_w[pch];
        end
    end

    // access answer is registered: the master reads it a cycle after it
    // changes ACC_CH, trading one cycle of latency for a clean timing path
    always_comb
    begin
        s_d = s_q;
        if (32'(ACC_CH) < NCH)
        begin
            s_d.addr = ptr_w[ACC_CH];
            s_d.bytes = bytes_w[ACC_CH];
        end
        else
        begin
            s_d.addr = 32'h0;
            s_d.bytes = 3'h0;
        end
        case (s_d.bytes)
            3'h4:
            begin
                s_d.hsize = uda_pkg::HSIZE_WORD;
            end
            3'h2:
            begin
                s_d.hsize = uda_pkg::HSIZE_HALF;
            end
            default:
            begin
                s_d.hsize = uda_pkg::HSIZE_BYTE;
            end
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            s_q <= '{addr: 32'h0, bytes: 3'h0, hsize: uda_pkg::HSIZE_BYTE};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign ACC_ADDR = s_q.addr;
    assign ACC_BYTES = s_q.bytes;
    assign ACC_HSIZE = s_q.hsize;
    assign CH_END = end_w;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence ptr0_read_addr;
        HSEL && HTRANS[1] && !HWRITE && HREADY
        && HADDR[11:0] == uda_pkg::PTR_BASE;
    endsequence

    sequence ptr0_read_data;
        !HREADYOUT ##1 HREADYOUT && HRDATA == $past(ptr_w[0]);
    endsequence

    a_ptr_reg_read: assert property (
        ptr0_read_addr |=> ptr0_read_data)
        else $error("channel 0 pointer not read at its offset");
    a_ptr_reg_stride: assert property (
        HSEL && HTRANS[1] && HWRITE && HREADY && !CH_ACTIVE[1]
        && HADDR[11:0] == uda_pkg::PTR_BASE + uda_pkg::CH_STRIDE
        && !DESC_LOAD[1]
        |=> ##1 ptr_w[1] == $past(HWDATA))
        else $error("channel 1 pointer not written at stride offset");
    a_acc_hsize_match: assert property (
        ACC_BYTES == 3'h4 |-> ACC_HSIZE == uda_pkg::HSIZE_WORD
        && ACC_ADDR[1:0] == 2'h0)
        else $error("word access with wrong size or alignment");

    // every register access keeps the fixed timing, not only pointer ones
    sequence bus_write_addr;
        HSEL && HTRANS[1] && HWRITE && HREADY;
    endsequence

    sequence bus_read_addr;
        HSEL && HTRANS[1] && !HWRITE && HREADY;
    endsequence

    sequence read_one_wait;
        !HREADYOUT ##1 HREADYOUT;
    endsequence

    // a transfer end on a channel whose stop bit is clear must not end it
    sequence xfer_end_unarmed;
        (USB_XFER_END & ~stop_w & ~end_w & ~USB_DEV_END) != '0 && !ADDR_END;
    endsequence

    a_bus_write_nowait: assert property (
        bus_write_addr |=> HREADYOUT && !HRESP)
        else $error("write data phase stalled or not okay");
    a_bus_read_wait: assert property (
        bus_read_addr |=> read_one_wait)
        else $error("read did not take exactly one wait state");
    a_acc_bytes_legal: assert property (
        ACC_BYTES == 3'h0 || ACC_BYTES == 3'h1 || ACC_BYTES == 3'h2
        || ACC_BYTES == 3'h4)
        else $error("access width not a legal bus size");
    a_acc_half_size: assert property (
        ACC_BYTES == 3'h2 |-> ACC_HSIZE == uda_pkg::HSIZE_HALF
        && !ACC_ADDR[0])
        else $error("halfword access with wrong size or alignment");
    a_acc_byte_size: assert property (
        ACC_BYTES != 3'h2 && ACC_BYTES != 3'h4
        |-> ACC_HSIZE == uda_pkg::HSIZE_BYTE)
        else $error("narrow access without byte size");
    a_acc_addr_follows: assert property (
        ACC_CH == 3'h1 |=> ACC_ADDR == $past(ptr_w[1]))
        else $error("access address does not follow channel pointer");
    a_desc_load_ch3: assert property (
        DESC_LOAD[3] |=> ptr_w[3] == $past(DESC_ADDR))
        else $error("descriptor load lost against another pointer source");
    a_dev_end_sets: assert property (
        USB_DEV_END != '0 |=> (CH_END & $past(USB_DEV_END))
        == $past(USB_DEV_END))
        else $error("usb device end did not end the channel");
    a_xfer_end_ignored: assert property (
        xfer_end_unarmed |=> (CH_END & $past(USB_XFER_END) & ~$past(stop_w)
        & ~$past(end_w) & ~$past(USB_DEV_END)) == '0)
        else $error("transfer end ended a channel without its stop bit");
endmodule

// ---- uda_pkg.sv ----
// constants shared by the dma address counter, its channels and the testbench
package uda_pkg;
    localparam int NCH = 7;
    localparam int ADDR_W = 32;
    localparam int PKT_W = 16;
    localparam logic [11:0] CTRL_BASE = 12'h300;
    localparam logic [11:0] PTR_BASE = 12'h304;
    localparam logic [11:0] BEND_BASE = 12'h308;
    localparam logic [11:0] STAT_BASE = 12'h30c;
    localparam logic [11:0] CH_STRIDE = 12'h010;
    localparam logic [11:0] PKT_BASE = 12'h380;
    localparam logic [11:0] PKT_STRIDE = 12'h008;
    localparam logic [1:0] FLD_CTRL = 2'h0;
    localparam logic [1:0] FLD_PTR = 2'h1;
    localparam logic [1:0] FLD_BEND = 2'h2;
    localparam logic [1:0] FLD_STAT = 2'h3;
    localparam int CTRL_STOP_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 1 - 1;
    localparam int STAT_END_BIT = 1;
    localparam int STAT_IGN_BIT = 2;
    localparam logic [31:0] PTR_RESET = 32'h0;
    localparam logic [31:0] BEND_RESET = 32'hffffffff;
    localparam logic CTRL_RESET = 1'b0;
    localparam logic [2:0] WORD_BYTES = 3'h4;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage
